// *** hdl/pmev_pkg.sv ***
// constants for the power event aggregator register block
package pmev_pkg;
    localparam int unsigned ADDR_W = 5;
    // byte offsets from the power block base
    localparam logic [4:0] OFS_PM_CTRL   = 5'h04;
    localparam logic [4:0] OFS_GPE_STS   = 5'h08;
    localparam logic [4:0] OFS_GPE_EN    = 5'h09;
    localparam logic [4:0] OFS_WSTS_A    = 5'h0C;
    localparam logic [4:0] OFS_WSTS_B    = 5'h0D;
    localparam logic [4:0] OFS_WEN_A     = 5'h0E;
    localparam logic [4:0] OFS_WEN_B     = 5'h0F;
    localparam logic [4:0] OFS_WMST_STS  = 5'h10;
    localparam logic [4:0] OFS_WMST_EN   = 5'h11;
    localparam logic [4:0] OFS_SMI_STS_A = 5'h12;
    localparam logic [4:0] OFS_SMI_STS_B = 5'h13;
    localparam logic [4:0] OFS_SMI_EN_A  = 5'h14;
    localparam logic [4:0] OFS_SMI_EN_B  = 5'h15;
    // field positions
    localparam int unsigned GLOBAL_SCI_ENABLE_BIT   = 0;
    localparam int unsigned GPE_EN_BIT   = 0;
    localparam int unsigned MFLAG_BIT    = 0;
    localparam int unsigned MGATE_BIT    = 0;
    localparam int unsigned RING_BIT     = 5;
    localparam int unsigned CIR_BIT      = 0;
    localparam int unsigned SMI_RING_EN  = 0;
    localparam int unsigned SMI_P12_BIT  = 4;
    localparam int unsigned SMI_CIR_EN   = 5;
    localparam int unsigned SMI_ROUTE_EN = 6;
    localparam int unsigned SMI_OUT_EN   = 7;
    localparam int unsigned SLP_SMI_BIT  = 7;
    // masks and reset value
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] SMI_A_MASK   = 8'hFE;
    localparam logic [7:0] SMI_B_LIVE   = 8'h13;
    localparam logic [7:0] SMI_B_RDCLR  = 8'h8C;
    localparam logic [7:0] SMI_B_EN_LO  = 8'h0F;
endpackage : pmev_pkg

// *** hdl/pmev_sync_edge.sv ***
// two-stage synchroniser with rising edge detect
`timescale 1ns/10ps
module pmev_sync_edge #(
    parameter int unsigned W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta;
    logic [W-1:0] level_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta    <= '0;
            level   <= '0;
            level_q <= '0;
        end else begin
            meta    <= async_in;
            level   <= meta;
            level_q <= level;
        end
    end

    // one pulse per low-to-high transition
    assign rise = level & ~level_q;
endmodule : pmev_sync_edge

// *** hdl/power_event_aggregator.sv ***
// wake, sci and group management interrupt aggregator with byte registers
`timescale 1ns/10ps
module power_event_aggregator
    import pmev_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic [7:0]        io_wdata,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    output logic      [7:0]        io_rdata,
    input  wire logic [7:0]        wake_src_a,
    input  wire logic [7:0]        wake_src_b,
    input  wire logic [7:0]        smi_src_a,
    input  wire logic [7:0]        smi_src_b,
    input  wire logic              irq_mux_serial_sel,
    output logic                   wake_pme_n_out,
    output logic                   wake_pme_oe,
    output logic                   sci_req,
    output logic                   group_mgmt_interrupt_out_n,
    output logic                   group_mgmt_interrupt_oe,
    output logic                   serirq_smi_req
);
    logic [7:0] global_sci_enable;
    logic [7:0] sci_gpe_enable;
    logic [7:0] wake_source_status_a;
    logic [7:0] wake_source_status_b;
    logic [7:0] wake_source_enable_a;
    logic [7:0] wake_source_enable_b;
    logic       wake_master_flag;
    logic [7:0] wake_master_gate;
    logic       wake_sci_status;
    logic [7:0] smi_enable_a;
    logic [7:0] smi_enable_b;
    logic [7:0] smi_latch_b;
    logic       smi_active;
    logic       smi_grp_q;
    logic       pme_drive;
    logic [7:0] wake_lvl_a;
    logic [7:0] wake_lvl_b;
    logic [7:0] wake_rise_a;
    logic [7:0] wake_rise_b;
    logic [7:0] smi_lvl_a;
    logic [7:0] smi_lvl_b;
    logic [7:0] smi_rise_a;
    logic [7:0] smi_rise_b;
    logic [7:0] smi_view_a;
    logic [7:0] smi_view_b;
    logic       smi_grp;
    logic       smi_wake_ev;
    logic       en_ev;
    logic       any_ev;
    logic       pending;
    logic       mst_clr;
    logic       sci_clr;

    // write or read strobe decode for one offset
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs,
                                 input logic s);
        return s && (a == ofs);
    endfunction : hit

    // sticky status update where a new set beats a same-cycle clear
    function automatic logic [7:0] sticky(input logic [7:0] old, input logic [7:0] set,
                                          input logic [7:0] clr);
        return (old & ~clr) | set;
    endfunction : sticky

    pmev_sync_edge #(.W(16)) u_wake_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({wake_src_b, wake_src_a}),
        .level    ({wake_lvl_b, wake_lvl_a}),
        .rise     ({wake_rise_b, wake_rise_a})
    );

    pmev_sync_edge #(.W(16)) u_smi_sync (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .async_in ({smi_src_b, smi_src_a}),
        .level    ({smi_lvl_b, smi_lvl_a}),
        .rise     ({smi_rise_b, smi_rise_a})
    );

    // live and latched management interrupt views
    assign smi_view_a = smi_lvl_a & SMI_A_MASK;
    assign smi_view_b = (smi_lvl_b & SMI_B_LIVE) | smi_latch_b;

    // group interrupt from both enable registers, with the sleep status bit ungated
    assign smi_grp = (|(smi_enable_a & smi_view_a))
                   | (smi_enable_a[SMI_RING_EN] & wake_source_status_a[RING_BIT])
                   | (|(smi_enable_b & SMI_B_EN_LO & smi_view_b))
                   | (smi_enable_b[SMI_P12_BIT] & smi_view_b[SMI_P12_BIT])
                   | (smi_enable_b[SMI_CIR_EN] & wake_source_status_a[CIR_BIT])
                   | smi_view_b[SLP_SMI_BIT];

    // wake events, including routed group interrupts
    assign smi_wake_ev = smi_enable_b[SMI_ROUTE_EN] & smi_grp & ~smi_grp_q;
    assign en_ev   = (|(wake_rise_a & wake_source_enable_a))
                   | (|(wake_rise_b & wake_source_enable_b))
                   | smi_wake_ev;
    assign any_ev  = en_ev;
    assign pending = (|(wake_source_status_a & wake_source_enable_a))
                   | (|(wake_source_status_b & wake_source_enable_b))
                   | (smi_enable_b[SMI_ROUTE_EN] & smi_grp);
    assign mst_clr = hit(io_addr, OFS_WMST_STS, io_wr) & io_wdata[MFLAG_BIT] & ~pending;
    assign sci_clr = hit(io_addr, OFS_GPE_STS, io_wr) & io_wdata[0] & ~pending;

    // control registers written by the host
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            global_sci_enable    <= REG_RESET;
            sci_gpe_enable       <= REG_RESET;
            wake_source_enable_a <= REG_RESET;
            wake_source_enable_b <= REG_RESET;
            wake_master_gate     <= REG_RESET;
            smi_enable_a         <= REG_RESET;
            smi_enable_b         <= REG_RESET;
        end else begin
            // unused bits are never stored, so they read zero
            if (hit(io_addr, OFS_PM_CTRL, io_wr))
                global_sci_enable <= {7'h00, io_wdata[GLOBAL_SCI_ENABLE_BIT]};
            if (hit(io_addr, OFS_GPE_EN, io_wr))
                sci_gpe_enable <= {7'h00, io_wdata[GPE_EN_BIT]};
            if (hit(io_addr, OFS_WEN_A, io_wr))
                wake_source_enable_a <= io_wdata;
            if (hit(io_addr, OFS_WEN_B, io_wr))
                wake_source_enable_b <= io_wdata;
            if (hit(io_addr, OFS_WMST_EN, io_wr))
                wake_master_gate <= {7'h00, io_wdata[MGATE_BIT]};
            if (hit(io_addr, OFS_SMI_EN_A, io_wr))
                smi_enable_a <= io_wdata;
            if (hit(io_addr, OFS_SMI_EN_B, io_wr))
                smi_enable_b <= io_wdata;
        end
    end

    // per-source wake status, write one to clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wake_source_status_a <= REG_RESET;
            wake_source_status_b <= REG_RESET;
        end else begin
            wake_source_status_a <= sticky(wake_source_status_a, wake_rise_a,
                hit(io_addr, OFS_WSTS_A, io_wr) ? io_wdata : 8'h00);
            wake_source_status_b <= sticky(wake_source_status_b, wake_rise_b,
                hit(io_addr, OFS_WSTS_B, io_wr) ? io_wdata : 8'h00);
        end
    end

    // master wake flag: set on an enabled edge, cleared only when idle
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            wake_master_flag <= 1'b0;
        else if (en_ev)
            wake_master_flag <= 1'b1;
        else if (mst_clr)
            wake_master_flag <= 1'b0;
    end

    // sci event status follows the same set and clear policy
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            wake_sci_status <= 1'b0;
        else if (any_ev)
            wake_sci_status <= 1'b1;
        else if (sci_clr)
            wake_sci_status <= 1'b0;
    end

    // read-clear management status bits; a new edge wins over the read
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            smi_latch_b <= REG_RESET;
        else
            smi_latch_b <= sticky(smi_latch_b, smi_rise_b & SMI_B_RDCLR,
                hit(io_addr, OFS_SMI_STS_B, io_rd) ? SMI_B_RDCLR : 8'h00);
    end

    // output stage: nPME, sci and group interrupt routing
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pme_drive               <= 1'b0;
            sci_req                 <= 1'b0;
            smi_active              <= 1'b0;
            smi_grp_q               <= 1'b0;
            group_mgmt_interrupt_oe <= 1'b0;
            serirq_smi_req          <= 1'b0;
        end else begin
            pme_drive  <= wake_master_flag & wake_master_gate[MGATE_BIT];
            sci_req    <= wake_sci_status & sci_gpe_enable[GPE_EN_BIT]
                        & global_sci_enable[GLOBAL_SCI_ENABLE_BIT];
            smi_active <= smi_grp;
            smi_grp_q  <= smi_grp;
            group_mgmt_interrupt_oe <= smi_enable_b[SMI_OUT_EN]
                                     & ~irq_mux_serial_sel;
            serirq_smi_req <= smi_enable_b[SMI_OUT_EN] & irq_mux_serial_sel & smi_grp;
        end
    end

    // pins low while asserted; only nPME is open-drain style, the group pin drives high while enabled
    assign wake_pme_n_out             = ~pme_drive;
    assign wake_pme_oe                = pme_drive;
    assign group_mgmt_interrupt_out_n = ~smi_active;

    // read data register; unmapped offsets return zero
    always_ff @(posedge ref_clk) begin
        if (!reset_n)
            io_rdata <= REG_RESET;
        else if (io_rd) begin
            unique case (io_addr)
                OFS_PM_CTRL:   io_rdata <= global_sci_enable;
                OFS_GPE_STS:   io_rdata <= {7'h00, wake_sci_status};
                OFS_GPE_EN:    io_rdata <= sci_gpe_enable;
                OFS_WSTS_A:    io_rdata <= wake_source_status_a;
                OFS_WSTS_B:    io_rdata <= wake_source_status_b;
                OFS_WEN_A:     io_rdata <= wake_source_enable_a;
                OFS_WEN_B:     io_rdata <= wake_source_enable_b;
                OFS_WMST_STS:  io_rdata <= {7'h00, wake_master_flag};
                OFS_WMST_EN:   io_rdata <= wake_master_gate;
                OFS_SMI_STS_A: io_rdata <= smi_view_a;
                OFS_SMI_STS_B: io_rdata <= smi_view_b;
                OFS_SMI_EN_A:  io_rdata <= smi_enable_a;
                OFS_SMI_EN_B:  io_rdata <= smi_enable_b;
                default:       io_rdata <= REG_RESET;
            endcase
        end
    end

    // checks on the behaviour above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_mst_clear;
        wake_master_flag && mst_clr && !en_ev ##1 !wake_master_flag;
    endsequence

    sequence s_route_edge;
        smi_enable_b[SMI_ROUTE_EN] && smi_grp && !smi_grp_q;
    endsequence

    property p_gpe_rsvd;
        hit(io_addr, OFS_GPE_EN, io_rd) |=> io_rdata[7:1] == 7'h00;
    endproperty
    a_gpe_rsvd: assert property (p_gpe_rsvd)
        else $error("reserved sci enable bits read nonzero");

    property p_sci_gate;
        $rose(sci_req) |-> $past(sci_gpe_enable[GPE_EN_BIT])
                           && $past(global_sci_enable[GLOBAL_SCI_ENABLE_BIT]);
    endproperty
    a_sci_gate: assert property (p_sci_gate)
        else $error("sci raised while disabled");

    property p_flag_set;
        en_ev |=> wake_master_flag && wake_sci_status;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("enabled wake edge did not set flags");

    property p_steady;
        !en_ev && !wake_master_flag |=> !wake_master_flag;
    endproperty
    a_steady: assert property (p_steady)
        else $error("master flag set without an edge");

    property p_clr_blocked;
        wake_master_flag && hit(io_addr, OFS_WMST_STS, io_wr) && pending
            |=> wake_master_flag;
    endproperty
    a_clr_blocked: assert property (p_clr_blocked)
        else $error("master flag cleared with events pending");

    property p_release;
        s_mst_clear |=> !wake_pme_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("nPME still driven after clear");

    property p_write_zero;
        wake_master_flag && hit(io_addr, OFS_WMST_STS, io_wr) && !io_wdata[MFLAG_BIT]
            |=> wake_master_flag;
    endproperty
    a_write_zero: assert property (p_write_zero)
        else $error("writing zero changed master flag");

    property p_gate_off;
        !wake_master_gate[MGATE_BIT] |=> !wake_pme_oe;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("nPME driven with gate off");

    property p_latch;
        |wake_rise_a |=> (wake_source_status_a & $past(wake_rise_a)) == $past(wake_rise_a);
    endproperty
    a_latch: assert property (p_latch)
        else $error("wake edge not latched in status");

    property p_w1c_keep;
        hit(io_addr, OFS_WSTS_A, io_wr)
            |=> (wake_source_status_a & $past(wake_source_status_a) & ~$past(io_wdata))
                == ($past(wake_source_status_a) & ~$past(io_wdata));
    endproperty
    a_w1c_keep: assert property (p_w1c_keep)
        else $error("status bit cleared without a one written");

    property p_smi_pin;
        smi_grp && smi_enable_b[SMI_OUT_EN] && !irq_mux_serial_sel
            |=> group_mgmt_interrupt_oe && !group_mgmt_interrupt_out_n;
    endproperty
    a_smi_pin: assert property (p_smi_pin)
        else $error("group interrupt not on pin");

    property p_p12;
        smi_enable_b[SMI_P12_BIT] && smi_lvl_b[SMI_P12_BIT] |=> smi_active;
    endproperty
    a_p12: assert property (p_p12)
        else $error("port bit not routed into group interrupt");

    property p_route;
        s_route_edge |=> wake_master_flag ##1 wake_pme_oe == $past(wake_master_gate[MGATE_BIT]);
    endproperty
    a_route: assert property (p_route)
        else $error("routed group event did not wake");
endmodule : power_event_aggregator

// *** tb/host_bus_model.sv ***
// host side model of the system io bus and the board pull-ups
`timescale 1ns/10ps
module host_bus_model
    import pmev_pkg::*;
(
    input  wire logic              ref_clk,
    output logic      [ADDR_W-1:0] io_addr,
    output logic      [7:0]        io_wdata,
    output logic                   io_wr,
    output logic                   io_rd,
    input  wire logic [7:0]        io_rdata,
    input  wire logic              pme_n_out,
    input  wire logic              pme_oe,
    input  wire logic              smi_n_out,
    input  wire logic              smi_oe,
    output logic                   pme_line,
    output logic                   smi_line
);
    // pull-ups hold released lines high
    assign pme_line = pme_oe ? pme_n_out : 1'b1;
    assign smi_line = smi_oe ? smi_n_out : 1'b1;
    // idle bus from time zero
    initial begin
        io_addr  = 5'h00;
        io_wdata = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
    end
    // one write; strobe held over one rising edge, data scrambled after
    task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr  = a;
        io_wdata = d; // caller may supply ones in unused bits
        io_wr    = 1'b1;
        @(negedge ref_clk);
        io_wr    = 1'b0;
        io_wdata = ~d;
    endtask : bus_write
    // one read; data registered at the taking edge
    task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge ref_clk);
        io_rd   = 1'b0;
        d       = io_rdata;
    endtask : bus_read
endmodule : host_bus_model

// *** tb/tb.sv ***
// self-checking bench for the power event aggregator
`timescale 1ns/10ps
module tb;
    import pmev_pkg::*;
    logic              ref_clk;
    logic              reset_n;
    logic [ADDR_W-1:0] io_addr;
    logic [7:0]        io_wdata;
    logic              io_wr;
    logic              io_rd;
    logic [7:0]        io_rdata;
    logic [7:0]        wake_src_a;
    logic [7:0]        wake_src_b;
    logic [7:0]        smi_src_a;
    logic [7:0]        smi_src_b;
    logic              irq_mux_serial_sel;
    logic              pme_n_out;
    logic              pme_oe;
    logic              sci_req;
    logic              smi_n_out;
    logic              smi_oe;
    logic              serirq_smi_req;
    logic              pme_line;
    logic              smi_line;
    int                n_fail;
    int                tests_run;
    localparam logic [4:0] MAPPED [13] = '{OFS_PM_CTRL, OFS_GPE_STS, OFS_GPE_EN, OFS_WSTS_A,
        OFS_WSTS_B, OFS_WEN_A, OFS_WEN_B, OFS_WMST_STS, OFS_WMST_EN, OFS_SMI_STS_A,
        OFS_SMI_STS_B, OFS_SMI_EN_A, OFS_SMI_EN_B};

    power_event_aggregator DUT (.ref_clk(ref_clk), .reset_n(reset_n), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .wake_src_a(wake_src_a), .wake_src_b(wake_src_b), .smi_src_a(smi_src_a),
        .smi_src_b(smi_src_b), .irq_mux_serial_sel(irq_mux_serial_sel),
        .wake_pme_n_out(pme_n_out), .wake_pme_oe(pme_oe), .sci_req(sci_req),
        .group_mgmt_interrupt_out_n(smi_n_out), .group_mgmt_interrupt_oe(smi_oe),
        .serirq_smi_req(serirq_smi_req));
    host_bus_model host (.ref_clk(ref_clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .pme_n_out(pme_n_out),
        .pme_oe(pme_oe), .smi_n_out(smi_n_out), .smi_oe(smi_oe), .pme_line(pme_line),
        .smi_line(smi_line));

    // free-running clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // verdict and end of run
    task automatic test_done();
        if (n_fail == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_cyc
    // register read compare
    task automatic check_reg(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] got;
        host.bus_read(a, got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t reg %h got %h exp %h", $time, a, got, exp);
        end
    endtask : check_reg
    // pin level compare
    task automatic check_pin(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t pin got %b exp %b", $time, got, exp);
        end
    endtask : check_pin
    task automatic do_reset();
        @(negedge ref_clk);
        reset_n = 1'b0;
        wait_cyc(4);
        reset_n = 1'b1;
    endtask : do_reset
    // every register and output at its reset value
    task automatic t_reset();
        foreach (MAPPED[i]) check_reg(MAPPED[i], REG_RESET);
        check_pin(pme_line, 1'b1);
        check_pin(smi_line, 1'b1);
        check_pin(sci_req, 1'b0);
        check_pin(serirq_smi_req, 1'b0);
    endtask : t_reset
    // unused bits and unmapped space
    task automatic t_reserved();
        host.bus_write(OFS_GPE_EN, 8'hFF);
        check_reg(OFS_GPE_EN, 8'h01);
        host.bus_write(OFS_GPE_EN, 8'h00);
        check_reg(5'h1F, 8'h00);
    endtask : t_reserved
    // disabled source latches status only, steady level sets nothing again
    task automatic t_disabled();
        host.bus_write(OFS_WMST_EN, 8'h01);
        wake_src_a = 8'h02;
        wait_cyc(6);
        check_reg(OFS_WSTS_A, 8'h02);
        check_reg(OFS_WMST_STS, 8'h00);
        check_pin(pme_line, 1'b1);
        host.bus_write(OFS_WSTS_A, 8'h00);
        check_reg(OFS_WSTS_A, 8'h02);
        host.bus_write(OFS_WSTS_A, 8'h02);
        wait_cyc(6);
        check_reg(OFS_WSTS_A, 8'h00);
        wake_src_a = 8'h00;
    endtask : t_disabled
    // enabled source: flag, gate, sci and clearing order
    task automatic t_enabled();
        host.bus_write(OFS_WMST_EN, 8'h00);
        host.bus_write(OFS_WEN_B, 8'h01);
        host.bus_write(OFS_GPE_EN, 8'h01);
        host.bus_write(OFS_PM_CTRL, 8'h01);
        wake_src_b = 8'h01;
        wait_cyc(6);
        check_reg(OFS_WSTS_B, 8'h01);
        check_reg(OFS_WMST_STS, 8'h01);
        check_pin(pme_line, 1'b1);
        check_pin(sci_req, 1'b1);
        check_reg(OFS_GPE_STS, 8'h01);
        host.bus_write(OFS_WMST_STS, 8'h00);
        check_reg(OFS_WMST_STS, 8'h01);
        host.bus_write(OFS_WMST_STS, 8'h01);
        check_reg(OFS_WMST_STS, 8'h01);
        host.bus_write(OFS_WMST_EN, 8'h01);
        wait_cyc(2);
        check_pin(pme_line, 1'b0);
        host.bus_write(OFS_PM_CTRL, 8'h00);
        wait_cyc(2);
        check_pin(sci_req, 1'b0);
        host.bus_write(OFS_PM_CTRL, 8'h01);
        host.bus_write(OFS_GPE_EN, 8'h00);
        wait_cyc(2);
        check_pin(sci_req, 1'b0);
        host.bus_write(OFS_GPE_EN, 8'h01);
        wake_src_b = 8'h00;
        host.bus_write(OFS_WSTS_B, 8'h01);
        check_reg(OFS_WSTS_B, 8'h00);
        host.bus_write(OFS_WMST_STS, 8'h01);
        check_reg(OFS_WMST_STS, 8'h00);
        check_pin(pme_line, 1'b1);
        host.bus_write(OFS_GPE_STS, 8'h01);
        check_reg(OFS_GPE_STS, 8'h00);
        check_pin(sci_req, 1'b0);
    endtask : t_enabled
    // group interrupt to pin, frame, keyboard routing and wake routing
    task automatic t_smi();
        host.bus_write(OFS_SMI_EN_A, 8'h80);
        host.bus_write(OFS_SMI_EN_B, 8'h80);
        irq_mux_serial_sel = 1'b0;
        smi_src_a = 8'h81;
        wait_cyc(6);
        check_reg(OFS_SMI_STS_A, 8'h80);
        check_pin(smi_line, 1'b0);
        check_pin(serirq_smi_req, 1'b0);
        irq_mux_serial_sel = 1'b1;
        wait_cyc(4);
        check_pin(smi_line, 1'b1);
        check_pin(serirq_smi_req, 1'b1);
        host.bus_write(OFS_SMI_EN_B, 8'h00);
        wait_cyc(3);
        check_pin(serirq_smi_req, 1'b0);
        smi_src_a = 8'h00;
        host.bus_write(OFS_SMI_EN_A, 8'h00);
        host.bus_write(OFS_SMI_EN_B, 8'h90);
        smi_src_b = 8'h10;
        wait_cyc(6);
        check_pin(serirq_smi_req, 1'b1);
        smi_src_b = 8'h00;
        wait_cyc(6);
        // edge-latched source: feeds the group, read returns it once then clears
        host.bus_write(OFS_SMI_EN_B, 8'h84);
        smi_src_b = 8'h04;
        wait_cyc(6);
        check_pin(serirq_smi_req, 1'b1);
        check_reg(OFS_SMI_STS_B, 8'h04);
        check_reg(OFS_SMI_STS_B, 8'h00);
        wait_cyc(3);
        check_pin(serirq_smi_req, 1'b0);
        smi_src_b = 8'h00;
        host.bus_write(OFS_SMI_EN_B, 8'hD0);
        smi_src_b = 8'h10;
        wait_cyc(6);
        check_reg(OFS_WMST_STS, 8'h01);
        check_pin(pme_line, 1'b0);
        smi_src_b = 8'h00;
    endtask : t_smi
    // main sequence
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_n = 1'b0;
        wake_src_a = 8'h00;
        wake_src_b = 8'h00;
        smi_src_a = 8'h00;
        smi_src_b = 8'h00;
        irq_mux_serial_sel = 1'b0;
        do_reset();
        t_reset();
        t_reserved();
        t_disabled();
        t_enabled();
        t_smi();
        do_reset();
        t_reset();
        test_done();
    end
endmodule : tb
